// [core/divp_top.sv]
// interrupt vector and priority logic: flag, mask and dma select registers,
// pin synchronisers and a fixed-priority arbiter handing slots to the core
// assumes peripheral pulses and core signals share clk_sys_in; pins are async
//
// How it works
// (RQ1) slots four words apart; traps 17-30 unprioritised
// (RQ2) reset to slot 00, nmi to 04
// (RQ3) external requests 0-2 to slots 40-48
// (RQ4) timer 0 and serial 0 to 4C-54
// (RQ5) slot 58 reserved, or dma channel 0
// (RQ6) slot 5C timer 1, or dma channel 1
// (RQ7) external 3 to 60, host to 64
// (RQ8) slot 68 serial 1 receive, or dma 2
// (RQ9) slot 6C serial 1 transmit, or dma 3
// (RQ10) dma 4 and 5 to 70, 74
// (RQ11) dma select register picks shared sources
// (RQ12) low flag/mask bits fixed; 15-14 reserved
// (RQ13) upper flag/mask bits per shared layout
// (RQ14) smallest priority number served first
// (RQ15) flag and mask both needed; reset, nmi unmasked
`timescale 1ns/100ps
`default_nettype none

module divp_top (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [divp_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [divp_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [divp_pkg::DATA_W-1:0] reg_rdata_out,
  input wire logic reset_pin_request_b_in,
  input wire logic nmi_request_b_in,
  input wire logic ext_request_zero_b_in,
  input wire logic ext_request_one_b_in,
  input wire logic ext_request_two_b_in,
  input wire logic ext_request_three_b_in,
  input wire divp_pkg::divp_src_t periph_req_in,
  input wire logic soft_reset_trap_in,
  input wire logic soft_trap_valid_in,
  input wire logic [4:0] soft_trap_num_in,
  input wire logic core_ready_in,
  output divp_pkg::divp_take_t take_out
);
  import divp_pkg::*;

  localparam int NUM_PINS = 6;

  // reset release through two flops
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // pin synchronisers; idle high so release gives no false edge
  logic [NUM_PINS-1:0] pin_raw;
  logic [NUM_PINS-1:0] pin_meta_r;
  logic [NUM_PINS-1:0] pin_sync_r;
  logic [NUM_PINS-1:0] pin_prev_r;
  logic [NUM_PINS-1:0] pin_fall;

  assign pin_raw = {reset_pin_request_b_in, nmi_request_b_in, ext_request_three_b_in,
                    ext_request_two_b_in, ext_request_one_b_in, ext_request_zero_b_in};

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PINS; gp++) begin : g_pin
      always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
          pin_meta_r[gp] <= 1'b1;
          pin_sync_r[gp] <= 1'b1;
          pin_prev_r[gp] <= 1'b1;
        end else begin
          pin_meta_r[gp] <= pin_raw[gp];
          pin_sync_r[gp] <= pin_meta_r[gp];
          pin_prev_r[gp] <= pin_sync_r[gp];
        end
      end
      // edge seen only past the second flop
      assign pin_fall[gp] = pin_prev_r[gp] & ~pin_sync_r[gp];
    end
  endgenerate

  wire ext0_fall = pin_fall[0];
  wire ext1_fall = pin_fall[1];
  wire ext2_fall = pin_fall[2];
  wire ext3_fall = pin_fall[3];
  wire nmi_fall = pin_fall[4];
  wire rst_pin_fall = pin_fall[5];

  // registers
  logic [DATA_W-1:0] flags_r;
  logic [DATA_W-1:0] flags_nxt;
  logic [DATA_W-1:0] mask_r;
  logic [3:0] dma_sel_r;
  logic reset_pend_r;
  logic nmi_pend_r;
  logic trap_pend_r;
  logic [4:0] trap_num_r;
  divp_take_t take_r;
  logic [DATA_W-1:0] rdata_r;

  // address decode
  wire wr_flags = reg_wr_in && (reg_addr_in == OFS_FLAGS);
  wire wr_mask = reg_wr_in && (reg_addr_in == OFS_MASK);
  wire wr_dma = reg_wr_in && (reg_addr_in == OFS_DMA_PRIO);

  // shared slots follow the select bits for flag and mask alike
  wire share6 = dma_sel_r[SEL_DMA0] & periph_req_in.dma_ch0_request; // (RQ5) (RQ11)
  wire share7 = dma_sel_r[SEL_DMA1] ? periph_req_in.dma_ch1_request
                                    : periph_req_in.timer_one_request; // (RQ6) (RQ11)
  wire share10 = dma_sel_r[SEL_DMA2] ? periph_req_in.dma_ch2_request
                                     : periph_req_in.serial1_rx_request; // (RQ8) (RQ11)
  wire share11 = dma_sel_r[SEL_DMA3] ? periph_req_in.dma_ch3_request
                                     : periph_req_in.serial1_tx_request; // (RQ9) (RQ11)

  logic [DATA_W-1:0] set_vec;
  always_comb begin
    set_vec = '0;
    set_vec[BIT_EXT0] = ext0_fall; // (RQ3) (RQ12)
    set_vec[BIT_EXT1] = ext1_fall; // (RQ3) (RQ12)
    set_vec[BIT_EXT2] = ext2_fall; // (RQ3) (RQ12)
    set_vec[BIT_TIMER0] = periph_req_in.timer_zero_request; // (RQ4) (RQ12)
    set_vec[BIT_SER0_RX] = periph_req_in.serial0_rx_request; // (RQ4) (RQ12)
    set_vec[BIT_SER0_TX] = periph_req_in.serial0_tx_request; // (RQ4) (RQ12)
    set_vec[BIT_SHARE_DMA0] = share6; // (RQ13)
    set_vec[BIT_SHARE_DMA1] = share7; // (RQ13)
    set_vec[BIT_EXT3] = ext3_fall; // (RQ7) (RQ13)
    set_vec[BIT_HOST] = periph_req_in.host_port_request; // (RQ7) (RQ13)
    set_vec[BIT_SHARE_DMA2] = share10; // (RQ13)
    set_vec[BIT_SHARE_DMA3] = share11; // (RQ13)
    set_vec[BIT_DMA4] = periph_req_in.dma_ch4_request; // (RQ10) (RQ13)
    set_vec[BIT_DMA5] = periph_req_in.dma_ch5_request; // (RQ10) (RQ13)
  end

  // arbitration
  function automatic logic [3:0] first_set(input logic [NUM_MASKABLE-1:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = NUM_MASKABLE - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : first_set

  wire [NUM_MASKABLE-1:0] live = flags_r[NUM_MASKABLE-1:0] & mask_r[NUM_MASKABLE-1:0]; // (RQ15)
  wire any_live = |live;
  wire [3:0] win_idx = first_set(live); // (RQ14)
  wire [6:0] win_slot = SLOT_MASK_BASE + {1'b0, win_idx, 2'b00}; // (RQ1)
  wire [4:0] win_prio = PRIO_MASK_BASE + {1'b0, win_idx}; // (RQ14)
  wire [6:0] trap_slot = {trap_num_r - TRAP_SLOT_BIAS, 2'b00}; // (RQ1)
  wire trap_ok = soft_trap_valid_in && (soft_trap_num_in >= TRAP_NMI)
                 && (soft_trap_num_in <= TRAP_LAST);

  divp_take_t pick;
  logic [DATA_W-1:0] take_clr;
  logic take_reset;
  logic take_nmi;
  logic take_trap;

  // reset ahead of nmi ahead of traps ahead of maskable sources
  always_comb begin
    pick = '0;
    take_clr = '0;
    take_reset = 1'b0;
    take_nmi = 1'b0;
    take_trap = 1'b0;
    if (reset_pend_r) begin
      pick = '{valid: 1'b1, slot: SLOT_RESET, prio: PRIO_RESET}; // (RQ2) (RQ15)
      take_reset = core_ready_in;
    end else if (nmi_pend_r) begin
      pick = '{valid: 1'b1, slot: SLOT_NMI, prio: PRIO_NMI}; // (RQ2) (RQ15)
      take_nmi = core_ready_in;
    end else if (trap_pend_r) begin
      // traps run from an instruction, so only trap 16 carries a level, that of nmi
      pick = '{valid: 1'b1, slot: trap_slot,
               prio: (trap_num_r == TRAP_NMI) ? PRIO_NMI : PRIO_NONE}; // (RQ1)
      take_trap = core_ready_in;
    end else if (any_live) begin
      pick = '{valid: 1'b1, slot: win_slot, prio: win_prio}; // (RQ14)
      take_clr[win_idx] = core_ready_in;
    end
  end

  // hardware set wins over software or take clear
  assign flags_nxt = (((flags_r & ~take_clr & ~(wr_flags ? reg_wdata_in : '0)))
                     | set_vec) & FLAGS_USED; // (RQ12)

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= FLAGS_RESET;
      mask_r <= MASK_RESET;
      dma_sel_r <= DMA_PRIO_RESET;
    end else begin
      flags_r <= flags_nxt;
      if (wr_mask) begin
        mask_r <= reg_wdata_in & FLAGS_USED; // (RQ12)
      end
      if (wr_dma) begin
        dma_sel_r <= reg_wdata_in[3:0]; // (RQ11)
      end
    end
  end

  // core comes out of reset owing the reset vector
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      reset_pend_r <= 1'b1;
      nmi_pend_r <= 1'b0;
    end else begin
      reset_pend_r <= rst_pin_fall | soft_reset_trap_in | (reset_pend_r & ~take_reset); // (RQ2)
      nmi_pend_r <= nmi_fall | (nmi_pend_r & ~take_nmi); // (RQ2)
    end
  end

  // one trap held; a second trap before the first is taken is dropped
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      trap_pend_r <= 1'b0;
      trap_num_r <= TRAP_NMI;
    end else if (trap_ok && (!trap_pend_r || take_trap)) begin
      trap_pend_r <= 1'b1;
      trap_num_r <= soft_trap_num_in;
    end else if (take_trap) begin
      trap_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      take_r <= '0;
    end else begin
      take_r <= core_ready_in ? pick : '0;
    end
  end

  // read path, answered the cycle after the strobe
  wire [DATA_W-1:0] status_word = {1'b0, reset_pend_r, nmi_pend_r, trap_pend_r,
                                   5'h00, pick.slot};
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    if (reg_addr_in == OFS_FLAGS) begin
      rd_mux = flags_r;
    end else if (reg_addr_in == OFS_MASK) begin
      rd_mux = mask_r;
    end else if (reg_addr_in == OFS_DMA_PRIO) begin
      rd_mux = {12'h000, dma_sel_r};
    end else if (reg_addr_in == OFS_STATUS) begin
      rd_mux = status_word;
    end else begin
      rd_mux = '0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= reg_rd_in ? rd_mux : '0;
    end
  end

  assign reg_rdata_out = rdata_r;
  assign take_out = take_r;

  property p_reset_first;
    @(posedge clk_sys_in) disable iff (!rst_n)
    (reset_pend_r && core_ready_in) |=> (take_r.valid && take_r.slot == 7'h00
                                         && take_r.prio == 5'h01);
  endproperty
  a_reset_first: assert property (p_reset_first) else $error("reset slot wrong"); // RQ2

  property p_nmi_slot;
    @(posedge clk_sys_in) disable iff (!rst_n)
    (!reset_pend_r && nmi_pend_r && core_ready_in)
      |=> (take_r.slot == 7'h04 && take_r.prio == 5'h02);
  endproperty
  a_nmi_slot: assert property (p_nmi_slot) else $error("nmi slot wrong"); // RQ2

  property p_slot_step;
    @(posedge clk_sys_in) disable iff (!rst_n)
    (take_r.valid && take_r.prio >= 5'h03)
      |-> (take_r.slot == 7'h40 + 7'({take_r.prio - 5'h03, 2'b00}));
  endproperty
  a_slot_step: assert property (p_slot_step) else $error("slot and priority mismatch"); // RQ1

  property p_masked_gate;
    @(posedge clk_sys_in) disable iff (!rst_n)
    (take_r.valid && take_r.prio >= 5'h03)
      |-> ((($past(live) >> (take_r.prio - 5'h03)) & 14'h0001) == 14'h0001);
  endproperty
  a_masked_gate: assert property (p_masked_gate) else $error("masked source taken"); // RQ15

  property p_lowest_first;
    @(posedge clk_sys_in) disable iff (!rst_n)
    (take_r.valid && take_r.prio >= 5'h03)
      |-> (($past(live) & ((14'h0001 << (take_r.prio - 5'h03)) - 14'h0001)) == 14'h0000);
  endproperty
  a_lowest_first: assert property (p_lowest_first) else $error("lower level skipped"); // RQ14

  property p_trap_range;
    @(posedge clk_sys_in) disable iff (!rst_n)
    (take_r.valid && take_r.prio == 5'h00)
      |-> (take_r.slot >= 7'h08 && take_r.slot <= 7'h3C);
  endproperty
  a_trap_range: assert property (p_trap_range) else $error("trap slot out of range"); // RQ1

  property p_reserved_zero;
    @(posedge clk_sys_in) disable iff (!rst_n)
    (flags_r[15:14] == 2'b00) && (mask_r[15:14] == 2'b00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set"); // RQ12

  property p_dma0_select;
    @(posedge clk_sys_in) disable iff (!rst_n)
    (periph_req_in.dma_ch0_request && dma_sel_r[0]) |=> flags_r[6];
  endproperty
  a_dma0_select: assert property (p_dma0_select) else $error("dma 0 flag lost"); // RQ5

  property p_timer1_default;
    @(posedge clk_sys_in) disable iff (!rst_n)
    (periph_req_in.timer_one_request && !dma_sel_r[1]) ##1 !flags_r[7] |-> 1'b0;
  endproperty
  a_timer1_default: assert property (p_timer1_default) else $error("timer 1 flag lost"); // RQ6

  property p_ext_edge;
    @(posedge clk_sys_in) disable iff (!rst_n)
    $fell(pin_sync_r[3]) |=> flags_r[8];
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("external 3 flag lost"); // RQ7

endmodule : divp_top

`default_nettype wire

// [core/divp_pkg.sv]
// package for the interrupt vector and priority block: offsets, layouts, slots
// assumes one 100 MHz clock domain shared with the core and the peripherals
package divp_pkg;

  // register port: word index on a narrow address
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_MASK = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_DMA_PRIO = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h3;

  // reset values
  localparam logic [DATA_W-1:0] FLAGS_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] MASK_RESET = 16'h0000;
  localparam logic [3:0] DMA_PRIO_RESET = 4'h0;
  localparam logic [DATA_W-1:0] FLAGS_USED = 16'h3FFF;

  // flag and mask bit positions
  localparam int NUM_MASKABLE = 14;
  localparam int BIT_EXT0 = 0;
  localparam int BIT_EXT1 = 1;
  localparam int BIT_EXT2 = 2;
  localparam int BIT_TIMER0 = 3;
  localparam int BIT_SER0_RX = 4;
  localparam int BIT_SER0_TX = 5;
  localparam int BIT_SHARE_DMA0 = 6;
  localparam int BIT_SHARE_DMA1 = 7;
  localparam int BIT_EXT3 = 8;
  localparam int BIT_HOST = 9;
  localparam int BIT_SHARE_DMA2 = 10;
  localparam int BIT_SHARE_DMA3 = 11;
  localparam int BIT_DMA4 = 12;
  localparam int BIT_DMA5 = 13;

  // select bits in the dma priority and enable register
  localparam int SEL_DMA0 = 0;
  localparam int SEL_DMA1 = 1;
  localparam int SEL_DMA2 = 2;
  localparam int SEL_DMA3 = 3;

  // vector slots and priorities
  localparam logic [6:0] SLOT_RESET = 7'h00;
  localparam logic [6:0] SLOT_NMI = 7'h04;
  localparam logic [6:0] SLOT_MASK_BASE = 7'h40;
  localparam logic [4:0] PRIO_NONE = 5'h00;
  localparam logic [4:0] PRIO_RESET = 5'h01;
  localparam logic [4:0] PRIO_NMI = 5'h02;
  localparam logic [4:0] PRIO_MASK_BASE = 5'h03;
  localparam logic [4:0] TRAP_NMI = 5'h10;
  localparam logic [4:0] TRAP_LAST = 5'h1E;
  localparam logic [4:0] TRAP_SLOT_BIAS = 5'h0F;

  // one-cycle event pulses from on-chip sources
  typedef struct packed {
    logic dma_ch5_request;
    logic dma_ch4_request;
    logic dma_ch3_request;
    logic dma_ch2_request;
    logic dma_ch1_request;
    logic dma_ch0_request;
    logic host_port_request;
    logic serial1_tx_request;
    logic serial1_rx_request;
    logic timer_one_request;
    logic serial0_tx_request;
    logic serial0_rx_request;
    logic timer_zero_request;
  } divp_src_t;

  // request handed to the core
  typedef struct packed {
    logic valid;
    logic [6:0] slot;
    logic [4:0] prio;
  } divp_take_t;

endpackage : divp_pkg

// [testbench/divp_core_model.sv]
// core-side partner: accepts vectors promptly, slowly or not at all
// assumes take_in is driven by the block on the same clock
`timescale 1ns/100ps
`default_nettype none

module divp_core_model (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic hold_in,
  input wire logic slow_in,
  input wire divp_pkg::divp_take_t take_in,
  output logic ready_out,
  output logic [15:0] n_taken_out
);
  import divp_pkg::*;
  logic phase_r;
  // slow mode accepts every other cycle only, like a busy pipeline
  assign ready_out = !hold_in && (!slow_in || phase_r);
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      phase_r <= 1'b0;
      n_taken_out <= 16'h0000;
    end else begin
      phase_r <= !phase_r;
      if (take_in.valid) begin
        n_taken_out <= n_taken_out + 16'h0001;
      end
    end
  end
endmodule : divp_core_model
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench for the interrupt vector and priority block
// assumes one 100 MHz clock; the core model sits on the take port
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import divp_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic rs_pin_b = 1'b1;
  logic nmi_b = 1'b1;
  logic [3:0] ext_b = 4'hF;
  divp_src_t src = '0;
  logic srt = 1'b0;
  logic tv = 1'b0;
  logic [4:0] tn = 5'h00;
  logic ready;
  logic hold = 1'b0;
  logic slow = 1'b0;
  logic [15:0] n_taken;
  divp_take_t take;
  int n_fail = 0;
  int compares = 0;

  always #5 clk_sys = !clk_sys;

  divp_top u_dut (.clk_sys_in(clk_sys), .rst_b_in(rst_b), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .reset_pin_request_b_in(rs_pin_b), .nmi_request_b_in(nmi_b),
    .ext_request_zero_b_in(ext_b[0]), .ext_request_one_b_in(ext_b[1]),
    .ext_request_two_b_in(ext_b[2]), .ext_request_three_b_in(ext_b[3]),
    .periph_req_in(src), .soft_reset_trap_in(srt), .soft_trap_valid_in(tv),
    .soft_trap_num_in(tn), .core_ready_in(ready), .take_out(take));

  divp_core_model u_core (.clk_in(clk_sys), .rst_b_in(rst_b), .hold_in(hold),
    .slow_in(slow), .take_in(take), .ready_out(ready), .n_taken_out(n_taken));

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_chk(input logic [3:0] a, input logic [15:0] exp, input string name);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(negedge clk_sys);
    chk(name, rdata, exp);
  endtask : reg_chk

  // bounded wait; a missing take shows as valid low in the compare
  task automatic expect_take(input logic [6:0] s, input logic [4:0] p);
    for (int i = 0; i < 24; i++) begin
      @(negedge clk_sys);
      if (take.valid === 1'b1) break;
    end
    chk("take", {3'h0, take}, {3'h0, 1'b1, s, p});
  endtask : expect_take

  // raise the source behind flag bit b, peripheral or dma side
  task automatic fire(input int b, input logic dma);
    logic [12:0] v;
    logic [3:0] pm;
    v = 13'h0000;
    pm = 4'h0;
    case (b)
      0, 1, 2: pm[b] = 1'b1;
      3, 4, 5: v[b-3] = 1'b1;
      6: v[7] = dma;
      7: v[dma ? 8 : 3] = 1'b1;
      9: v[6] = 1'b1;
      10, 11: v[dma ? b-1 : b-6] = 1'b1;
      12, 13: v[b-1] = 1'b1;
      default: pm[3] = 1'b1;
    endcase
    @(posedge clk_sys);
    src <= divp_src_t'(v);
    ext_b <= ~pm;
    @(posedge clk_sys);
    src <= '0;
    @(posedge clk_sys);
    ext_b <= 4'hF;
  endtask : fire

  task automatic pins(input logic rs, input logic nm);
    @(posedge clk_sys);
    rs_pin_b <= !rs;
    nmi_b <= !nm;
    repeat (3) @(posedge clk_sys);
    rs_pin_b <= 1'b1;
    nmi_b <= 1'b1;
  endtask : pins

  task automatic trap(input logic [4:0] n);
    @(posedge clk_sys);
    tv <= 1'b1;
    tn <= n;
    @(posedge clk_sys);
    tv <= 1'b0;
  endtask : trap

  task automatic t_reset();
    expect_take(7'h00, 5'h01);
    reg_chk(4'h0, 16'h0000, "flags");
    reg_chk(4'h2, 16'h0000, "dma_sel");
    reg_wr(4'h1, 16'hFFFF);
    reg_chk(4'h1, 16'h3FFF, "mask");
    reg_wr(4'h7, 16'hFFFF);
    reg_chk(4'h7, 16'h0000, "unmapped");
  endtask : t_reset

  task automatic t_table();
    int dl[4] = '{6, 7, 10, 11};
    for (int b = 0; b < 14; b++) begin
      if (b == 6) continue;
      fire(b, 1'b0);
      expect_take(7'(64 + 4 * b), 5'(3 + b));
    end
    fire(6, 1'b1);
    reg_chk(4'h0, 16'h0000, "slot58_reserved");
    reg_wr(4'h2, 16'h000F);
    slow <= 1'b1;
    foreach (dl[i]) begin
      fire(dl[i], 1'b1);
      expect_take(7'(64 + 4 * dl[i]), 5'(3 + dl[i]));
    end
    // peripheral side must be cut off while dma owns the slot
    hold <= 1'b1;
    fire(7, 1'b0);
    fire(10, 1'b0);
    reg_chk(4'h0, 16'h0000, "shared_cut");
    hold <= 1'b0;
    slow <= 1'b0;
    reg_wr(4'h2, 16'h0000);
  endtask : t_table

  task automatic t_prio();
    hold <= 1'b1;
    fire(13, 1'b0);
    fire(9, 1'b0);
    fire(4, 1'b0);
    trap(5'd20);
    pins(1'b1, 1'b1);
    repeat (6) @(posedge clk_sys);
    reg_chk(4'h0, 16'h2210, "flags_pend");
    reg_chk(4'h3, 16'h7000, "status_pend");
    hold <= 1'b0;
    expect_take(7'h00, 5'h01);
    expect_take(7'h04, 5'h02);
    expect_take(7'h14, 5'h00);
    expect_take(7'h50, 5'h07);
    expect_take(7'h64, 5'h0C);
    expect_take(7'h74, 5'h10);
  endtask : t_prio

  task automatic t_mask();
    logic [15:0] n0;
    reg_wr(4'h1, 16'h0000);
    fire(3, 1'b0);
    n0 = n_taken;
    repeat (8) @(posedge clk_sys);
    chk("masked_take", n_taken - n0, 16'h0000);
    reg_chk(4'h0, 16'h0008, "masked_flag");
    reg_wr(4'h0, 16'h0008);
    reg_chk(4'h0, 16'h0000, "flag_clear");
    pins(1'b0, 1'b1);
    expect_take(7'h04, 5'h02);
    reg_wr(4'h1, 16'hFFFF);
  endtask : t_mask

  task automatic t_traps();
    for (int n = 16; n <= 30; n++) begin
      trap(5'(n));
      expect_take(7'(4 * (n - 15)), (n == 16) ? 5'h02 : 5'h00);
    end
    @(posedge clk_sys);
    srt <= 1'b1;
    @(posedge clk_sys);
    srt <= 1'b0;
    expect_take(7'h00, 5'h01);
  endtask : t_traps

  task automatic print_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset();
    t_table();
    t_prio();
    t_mask();
    t_traps();
    print_verdict();
  end

  // whole run is a few hundred cycles; this is far beyond it
  initial begin
    #200us;
    n_fail++;
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
